// ---- logic/csn_pkg.sv ----
// Shared constants for the card session controller
package csn_pkg;
    // ------------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] ATR_OFS = 8'h0c;
    // CTRL fields
    localparam int CTRL_ACTIVE = 0;
    localparam int CTRL_WARM = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_T1 = 3;
    // CFG fields
    localparam int CFG_FEAT_LO = 0;
    localparam int CFG_HIGH_LO = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_9500;
    // ------------------------------------------------------------------
    // Transmission factors and feature bitmap
    // ------------------------------------------------------------------
    localparam logic [7:0] FIDI_DEFAULT = 8'h11;
    localparam logic [7:0] FIDI_512_8 = 8'h94;
    localparam logic [7:0] FIDI_512_16 = 8'h95;
    localparam logic [7:0] FEAT_NONE = 8'h00;
    localparam int FEAT_LOW_IMP = 0;
    localparam int FEAT_IC_USB = 1;
    localparam int FEAT_CLF = 2;
    localparam int FEAT_SEC_CH = 3;
    localparam int FEAT_SEC_APDU = 4;
    localparam logic [7:0] FEAT_DEFINED = 8'h1f;
    // Clock stop field of the first global A-type byte
    localparam int CSTOP_HI = 7;
    localparam int CSTOP_LO = 6;
    // ------------------------------------------------------------------
    // Timing in card clock cycles, retry limit and counter widths
    // ------------------------------------------------------------------
    localparam int STOP_WAIT_CYC = 1860;
    localparam int RESTART_CYC = 744;
    localparam int RESET_HOLD_CYC = 400;
    localparam int MAX_ATR_ERR = 3;
    localparam int CNT_W = 12;
    localparam int ERR_W = 2;
endpackage

// ---- logic/csn_clk_div.sv ----
// Card clock divider with a tick on each card clock rising edge
`timescale 1ns/100ps
module csn_clk_div #(
    parameter int HALF = 10
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic run,
    // Card clock
    output logic cardClk,
    output logic rise
);
    initial begin
        if (HALF < 1 || HALF > 255) begin
            $error("csn_clk_div: HALF out of range");
        end
    end

    logic [7:0] divCnt_q;

    // Stops only while low, so the card never sees a short pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            divCnt_q <= 8'h00;
            cardClk <= 1'b0;
        end else if (divCnt_q == 8'(HALF - 1)) begin
            divCnt_q <= 8'h00;
            if (run || cardClk) begin
                cardClk <= ~cardClk;
            end
        end else begin
            divCnt_q <= divCnt_q + 8'h01;
        end
    end

    assign rise = (divCnt_q == 8'(HALF - 1)) && run && !cardClk;
endmodule

// ---- logic/csn_ahb_regs.sv ----
// AHB-Lite slave holding the controller registers
`timescale 1ns/100ps
module csn_ahb_regs (
    // System
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register contents
    output logic [31:0] ctrlQ,
    output logic warmPulse,
    output logic [31:0] cfgQ,
    input wire logic [31:0] statusWord,
    input wire logic [31:0] atrWord
);
    logic wrPend_q;
    logic [7:0] wrAddr_q;

    function automatic logic [31:0] readMux(input logic [7:0] a,
                                            input logic [31:0] c,
                                            input logic [31:0] g,
                                            input logic [31:0] s,
                                            input logic [31:0] t);
        unique case (a)
            csn_pkg::CTRL_OFS: readMux = c;
            csn_pkg::CFG_OFS: readMux = g;
            csn_pkg::STATUS_OFS: readMux = s;
            csn_pkg::ATR_OFS: readMux = t;
            default: readMux = 32'h0000_0000;
        endcase
    endfunction

    wire logic take = hsel && hready && htrans[1] && hsize == 3'h2;

    // Zero wait states: read data is latched in the address phase
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend_q <= take && hwrite;
            wrAddr_q <= haddr;
            if (take && !hwrite) begin
                hrdata <= readMux(haddr, ctrlQ, cfgQ, statusWord, atrWord);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlQ <= 32'h0000_0000;
            cfgQ <= csn_pkg::CFG_RESET;
            warmPulse <= 1'b0;
        end else begin
            warmPulse <= 1'b0;
            if (wrPend_q && wrAddr_q == csn_pkg::CTRL_OFS) begin
                ctrlQ <= hwdata & 32'h0000_000d;
                warmPulse <= hwdata[csn_pkg::CTRL_WARM];
            end
            if (wrPend_q && wrAddr_q == csn_pkg::CFG_OFS) begin
                cfgQ <= hwdata & 32'h0000_ffff;
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

// ---- logic/csn_terminal.sv ----
// Terminal-side session controller for a contact card link
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
module csn_terminal #(
    parameter int CLK_HALF = 10
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Card contacts
    output logic cardClk,
    output logic cardRstN,
    // Answer-to-reset from the character layer
    input wire logic atrDone,
    input wire logic atrError,
    input wire logic [7:0] atrFiDi,
    input wire logic atrGlobBPresent,
    input wire logic [7:0] atrGlobB,
    input wire logic [7:0] atrGlobA,
    // Negotiation to and from the character layer
    output logic ppsStart,
    output logic [7:0] ppsFiDi,
    output logic ppsSend2,
    output logic [7:0] pps2,
    input wire logic ppsDone,
    input wire logic ppsOk,
    // Session state
    input wire logic respDone,
    output logic cmdReady,
    output logic [7:0] fidiUse,
    output logic protoT1,
    output logic parityEn,
    output logic coldReset,
    output logic rejected
);
    // ------------------------------------------------------------------
    // Registers and clock
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        S_OFF = 9'b000000001,
        S_RESET = 9'b000000010,
        S_ATR = 9'b000000100,
        S_PPS = 9'b000001000,
        S_READY = 9'b000010000,
        S_STOPWAIT = 9'b000100000,
        S_STOPPED = 9'b001000000,
        S_RESTART = 9'b010000000,
        S_REJECT = 9'b100000000
    } csn_state_type;

    csn_state_type state_q;
    logic [31:0] ctrlQ, cfgQ, statusWord, atrWord;
    logic warmPulse, rise, clkRun;
    logic [csn_pkg::CNT_W-1:0] cnt_q;
    logic [csn_pkg::ERR_W-1:0] errCnt_q;
    logic triedHigh_q, ppsWait_q, ppsOk_q;
    logic [7:0] ta1_q, globA_q, globB_q, reqFiDi_d;
    logic globBPres_q;

    function automatic logic fidiKnown(input logic [7:0] f);
        fidiKnown = f == csn_pkg::FIDI_DEFAULT || f == csn_pkg::FIDI_512_8
            || f == csn_pkg::FIDI_512_16;
    endfunction

    csn_ahb_regs u_regs (
        .clk(clk),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .ctrlQ(ctrlQ),
        .warmPulse(warmPulse),
        .cfgQ(cfgQ),
        .statusWord(statusWord),
        .atrWord(atrWord)
    );

    csn_clk_div #(.HALF(CLK_HALF)) u_div (
        .clk(clk),
        .rst(rst),
        .run(clkRun),
        .cardClk(cardClk),
        .rise(rise)
    );

    wire logic active = ctrlQ[csn_pkg::CTRL_ACTIVE];
    wire logic stopReq = ctrlQ[csn_pkg::CTRL_STOP];
    wire logic [7:0] termFeat = cfgQ[csn_pkg::CFG_FEAT_LO +: 8];
    wire logic [7:0] termHigh = cfgQ[csn_pkg::CFG_HIGH_LO +: 8];
    // Indication 00 means clock stop not supported
    wire logic stopAllowed =
        globA_q[csn_pkg::CSTOP_HI:csn_pkg::CSTOP_LO] != 2'b00;
    wire logic [7:0] shared = termFeat & globB_q & csn_pkg::FEAT_DEFINED;
    wire logic [7:0] atrShared = termFeat & atrGlobB & csn_pkg::FEAT_DEFINED;

    // ------------------------------------------------------------------
    // Negotiation choice
    // ------------------------------------------------------------------
    always_comb begin
        if (fidiKnown(atrFiDi)) begin
            reqFiDi_d = atrFiDi;
        end else if (!triedHigh_q && fidiKnown(termHigh)) begin
            reqFiDi_d = termHigh;
        end else begin
            reqFiDi_d = csn_pkg::FIDI_DEFAULT;
        end
    end

    // ------------------------------------------------------------------
    // Session sequencer
    // ------------------------------------------------------------------
    wire logic cntHit = cnt_q == csn_pkg::CNT_W'(csn_pkg::RESET_HOLD_CYC);
    wire logic goodAtr = atrDone && !atrError;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= S_OFF;
            cnt_q <= '0;
        end else if (!active && state_q != S_OFF) begin
            state_q <= S_OFF;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                S_OFF: begin
                    cnt_q <= '0;
                    if (active) begin
                        state_q <= S_RESET;
                    end
                end
                S_RESET: begin
                    if (cntHit) begin
                        state_q <= S_ATR;
                        cnt_q <= '0;
                    end else if (rise) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_ATR: begin
                    if (atrError) begin
                        state_q <= (errCnt_q ==
                            csn_pkg::ERR_W'(csn_pkg::MAX_ATR_ERR - 1))
                            ? S_REJECT : S_RESET;
                    end else if (atrDone) begin
                        state_q <= (reqFiDi_d != csn_pkg::FIDI_DEFAULT
                            || (atrGlobBPresent && atrShared != '0))
                            ? S_PPS : S_READY;
                    end
                end
                S_PPS: begin
                    if (ppsWait_q && ppsDone) begin
                        state_q <= ppsOk ? S_READY : S_RESET;
                    end
                end
                S_READY: begin
                    if (warmPulse) begin
                        state_q <= S_RESET;
                        cnt_q <= '0;
                    end else if (respDone) begin
                        cnt_q <= '0;
                    end else if (stopReq && stopAllowed) begin
                        state_q <= S_STOPWAIT;
                    end
                end
                S_STOPWAIT: begin
                    if (respDone || !stopReq) begin
                        state_q <= S_READY;
                        cnt_q <= respDone ? '0 : cnt_q;
                    end else if (cnt_q >= csn_pkg::CNT_W'(
                        csn_pkg::STOP_WAIT_CYC) && !cardClk && !rise) begin
                        state_q <= S_STOPPED;
                    end else if (rise) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_STOPPED: begin
                    cnt_q <= '0;
                    if (!stopReq) begin
                        state_q <= S_RESTART;
                    end
                end
                S_RESTART: begin
                    if (cnt_q >= csn_pkg::CNT_W'(csn_pkg::RESTART_CYC)) begin
                        state_q <= S_READY;
                        cnt_q <= '0;
                    end else if (rise) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_REJECT: begin
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Answer capture, error count, negotiation handshake
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || state_q == S_OFF) begin
            errCnt_q <= '0;
        end else if (state_q == S_ATR && atrError) begin
            errCnt_q <= errCnt_q + 1'b1;
        end else if (state_q == S_ATR && goodAtr) begin
            errCnt_q <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ta1_q <= csn_pkg::FIDI_DEFAULT;
            globA_q <= 8'h00;
            globB_q <= csn_pkg::FEAT_NONE;
            globBPres_q <= 1'b0;
        end else if (state_q == S_ATR && goodAtr) begin
            ta1_q <= atrFiDi;
            globA_q <= atrGlobA;
            globB_q <= atrGlobBPresent ? atrGlobB : csn_pkg::FEAT_NONE;
            globBPres_q <= atrGlobBPresent;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ppsStart <= 1'b0;
            ppsWait_q <= 1'b0;
            ppsFiDi <= csn_pkg::FIDI_DEFAULT;
            ppsSend2 <= 1'b0;
            pps2 <= csn_pkg::FEAT_NONE;
            triedHigh_q <= 1'b0;
            ppsOk_q <= 1'b0;
        end else begin
            ppsStart <= 1'b0;
            if (state_q == S_OFF) begin
                triedHigh_q <= 1'b0;
            end
            if (state_q == S_RESET) begin
                ppsOk_q <= 1'b0;
            end
            if (state_q == S_ATR && goodAtr) begin
                ppsFiDi <= reqFiDi_d;
                ppsSend2 <= atrGlobBPresent && atrShared != 8'h00;
            end
            if (state_q == S_PPS && !ppsWait_q) begin
                ppsStart <= 1'b1;
                ppsWait_q <= 1'b1;
                pps2 <= ppsSend2 ? shared : csn_pkg::FEAT_NONE;
                if (ppsFiDi == termHigh && !fidiKnown(ta1_q)) begin
                    triedHigh_q <= 1'b1;
                end
            end
            if (state_q == S_PPS && ppsWait_q && ppsDone) begin
                ppsWait_q <= 1'b0;
                ppsOk_q <= ppsOk;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || state_q == S_OFF) begin
            coldReset <= 1'b1;
        end else if (state_q == S_ATR && atrDone) begin
            coldReset <= 1'b0; // later resets are warm
        end
    end

    // ------------------------------------------------------------------
    // Outputs and status
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cardRstN <= 1'b0;
            fidiUse <= csn_pkg::FIDI_DEFAULT;
            protoT1 <= 1'b0;
        end else begin
            cardRstN <= !(state_q inside {S_OFF, S_RESET, S_REJECT});
            if (state_q inside {S_OFF, S_RESET}) begin
                fidiUse <= csn_pkg::FIDI_DEFAULT;
            end else if (state_q == S_PPS && ppsWait_q && ppsDone
                         && ppsOk) begin
                fidiUse <= ppsFiDi;
            end
            protoT1 <= ctrlQ[csn_pkg::CTRL_T1];
        end
    end

    assign clkRun = !(state_q inside {S_OFF, S_STOPPED, S_REJECT});
    assign cmdReady = state_q == S_READY;
    assign rejected = state_q == S_REJECT;
    assign parityEn = state_q != S_ATR && !protoT1;
    assign statusWord = {8'h00, ppsFiDi, 3'b000, globBPres_q, ppsOk_q,
                         errCnt_q, rejected, state_q[7:0]};
    assign atrWord = {8'h00, globA_q, globB_q, ta1_q};

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_stop_needs_ok: assert property (state_q == S_STOPPED |-> stopAllowed
        && cardClk == 1'b0) else $error("clock stopped unallowed");
    a_stop_wait_len: assert property (state_q == S_STOPWAIT
        ##1 state_q == S_STOPPED |-> $past(cnt_q) >= csn_pkg::STOP_WAIT_CYC)
        else $error("clock stop too early");
    a_restart_len: assert property ($rose(cmdReady) && $past(state_q)
        == S_RESTART |-> $past(cnt_q) >= csn_pkg::RESTART_CYC)
        else $error("command too soon after restart");
    a_fidi_default: assert property (fidiUse != csn_pkg::FIDI_DEFAULT
        |-> ppsOk_q) else $error("factors used without negotiation");
    a_err_retry: assert property (state_q == S_ATR && atrError && errCnt_q
        < 2'd2 && active |=> state_q == S_RESET ##1 !cardRstN)
        else $error("faulty answer not retried");
    a_reject_three: assert property ($rose(rejected) |-> $past(errCnt_q)
        == 2'd2 && $past(atrError)) else $error("early rejection");
    a_good_clears: assert property (state_q == S_ATR && goodAtr |=>
        errCnt_q == 2'd0) else $error("error count not cleared");
    a_parity_atr: assert property (state_q == S_ATR |-> !parityEn)
        else $error("parity active in answer");
    a_pps2_gate: assert property (ppsStart && ppsSend2 |-> globBPres_q
        && (pps2 & ~termFeat) == 8'h00)
        else $error("second byte unwarranted");
    a_ready_after: assert property ($rose(cmdReady) |-> $past(state_q)
        inside {S_ATR, S_PPS, S_RESTART, S_STOPWAIT})
        else $error("commands before answer");

    c_good_session: cover property (state_q == S_PPS ##[1:300]
        state_q == S_READY);
    c_clock_stop: cover property (state_q == S_STOPPED ##[1:1000]
        state_q == S_RESTART);
    c_reject: cover property ($rose(rejected));
endmodule

// ---- verif/csn_card_model.sv ----
// Card model answering resets and negotiation requests
`timescale 1ns/100ps
module csn_card_model (
    // System and bench settings
    input wire logic clk,
    input wire logic [7:0] ta1,
    input wire logic [7:0] globB,
    input wire logic [7:0] globA,
    input wire logic badAtr,
    input wire logic ppsAccept,
    // Terminal side
    input wire logic cardRstN,
    input wire logic ppsStart,
    output logic atrDone,
    output logic atrError,
    output logic [7:0] atrFiDi,
    output logic atrGlobBPresent,
    output logic [7:0] atrGlobB,
    output logic [7:0] atrGlobA,
    output logic ppsDone,
    output logic ppsOk
);
    logic rstOld = 1'b0;
    int atrCnt = 0;
    int ppsCnt = 0;
    // Same answer after every reset; negotiation accepted only while ppsAccept is set
    always @(posedge clk) begin
        rstOld <= cardRstN;
        if (cardRstN && !rstOld) atrCnt <= 20;
        else if (atrCnt != 0) atrCnt <= atrCnt - 1;
        if (ppsStart) ppsCnt <= 30;
        else if (ppsCnt != 0) ppsCnt <= ppsCnt - 1;
    end
    assign atrDone = atrCnt == 1;
    assign atrError = atrDone & badAtr;
    // Inverted outside the pulse so stale values never pass
    assign atrFiDi = atrDone ? ta1 : ~ta1;
    assign atrGlobBPresent = atrDone;
    assign atrGlobB = atrDone ? globB : ~globB;
    assign atrGlobA = atrDone ? globA : ~globA;
    assign ppsDone = ppsCnt == 1;
    assign ppsOk = ppsDone ? ppsAccept : ~ppsAccept;
endmodule

// ---- verif/csn_terminal_tb.sv ----
// Self-checking bench for the card session controller
`timescale 1ns/100ps
module csn_terminal_tb;
    logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, respDone = 1'b0;
    logic badAtr = 1'b0, ppsAccept = 1'b1;
    logic [1:0] htrans = 2'h0;
    logic [7:0] haddr = 8'h00, ta1 = 8'h11, globB = 8'h00, globA = 8'h00;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hready, hreadyout, hresp, cardClk, cardRstN, atrDone, atrError;
    logic atrGlobBPresent, ppsStart, ppsSend2, ppsDone, ppsOk, cmdReady;
    logic protoT1, parityEn, coldReset, rejected;
    logic [7:0] atrFiDi, atrGlobB, atrGlobA, ppsFiDi, pps2, fidiUse;
    int failCount = 0, checked = 0, errs;
    assign hready = hreadyout;
    always #5 clk = ~clk;
    // Short card clock keeps the long counts affordable
    csn_terminal #(.CLK_HALF(2)) uut (.clk(clk), .rst(rst), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .cardClk(cardClk),
        .cardRstN(cardRstN), .atrDone(atrDone), .atrError(atrError),
        .atrFiDi(atrFiDi), .atrGlobBPresent(atrGlobBPresent),
        .atrGlobB(atrGlobB), .atrGlobA(atrGlobA), .ppsStart(ppsStart),
        .ppsFiDi(ppsFiDi), .ppsSend2(ppsSend2), .pps2(pps2),
        .ppsDone(ppsDone), .ppsOk(ppsOk), .respDone(respDone),
        .cmdReady(cmdReady), .fidiUse(fidiUse), .protoT1(protoT1),
        .parityEn(parityEn), .coldReset(coldReset), .rejected(rejected));
    csn_card_model card (.clk(clk), .ta1(ta1), .globB(globB),
        .globA(globA), .badAtr(badAtr), .ppsAccept(ppsAccept),
        .cardRstN(cardRstN), .ppsStart(ppsStart), .atrDone(atrDone),
        .atrError(atrError), .atrFiDi(atrFiDi),
        .atrGlobBPresent(atrGlobBPresent), .atrGlobB(atrGlobB),
        .atrGlobA(atrGlobA), .ppsDone(ppsDone), .ppsOk(ppsOk));
    // ------------------------------------------------------------------
    // Bus cycles and checks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk(hresp, 1'b0);
    endtask
    // Bounded wait; a timeout shows up as a failed compare
    task automatic waitFor(ref logic s, input int lim);
        for (int n = 0; n < lim && s !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(s, 1'b1);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic negTest();
        bus(0, csn_pkg::CFG_OFS, 0);
        chk(rd, csn_pkg::CFG_RESET);
        bus(0, 8'h10, 0);
        chk(rd, 32'h0);
        bus(1, csn_pkg::CFG_OFS, 32'h0000_9503);
        ta1 <= csn_pkg::FIDI_512_8;
        globB <= 8'h06;
        globA <= 8'h40;
        bus(1, csn_pkg::CTRL_OFS, 32'h1);
        waitFor(cardRstN, 3000);
        chk(coldReset, 1'b1);
        chk(cmdReady, 1'b0);
        waitFor(ppsStart, 200);
        chk(ppsFiDi, csn_pkg::FIDI_512_8);
        chk(ppsSend2, 1'b1);
        chk(pps2, 8'h02);
        chk(fidiUse, csn_pkg::FIDI_DEFAULT);
        waitFor(cmdReady, 200);
        chk(fidiUse, csn_pkg::FIDI_512_8);
        bus(0, csn_pkg::ATR_OFS, 0);
        chk(rd, 32'h0040_0694);
    endtask
    task automatic stopTest();
        bus(1, csn_pkg::CTRL_OFS, 32'h5);
        repeat (4000) @(posedge clk);
        respDone <= 1'b1;
        @(posedge clk);
        respDone <= 1'b0;
        repeat (7200) @(posedge clk);
        bus(0, csn_pkg::STATUS_OFS, 0);
        chk(rd[7:0], 8'h20);
        repeat (320) @(posedge clk);
        bus(0, csn_pkg::STATUS_OFS, 0);
        chk(rd[7:0], 8'h40);
        chk(cardClk, 1'b0);
        bus(1, csn_pkg::CTRL_OFS, 32'h1);
        repeat (2880) @(posedge clk);
        chk(cmdReady, 1'b0);
        waitFor(cmdReady, 400);
    endtask
    task automatic fallTest();
        bus(1, csn_pkg::CTRL_OFS, 32'h0);
        ta1 <= 8'h37;
        globB <= 8'h00;
        globA <= 8'h00;
        ppsAccept <= 1'b0;
        bus(1, csn_pkg::CTRL_OFS, 32'h1);
        waitFor(ppsStart, 3000);
        chk(ppsFiDi, 8'h95);
        chk(ppsSend2, 1'b0);
        #20;
        waitFor(cmdReady, 4000);
        chk(ppsFiDi, csn_pkg::FIDI_DEFAULT);
        chk(fidiUse, csn_pkg::FIDI_DEFAULT);
        chk(coldReset, 1'b0);
        chk(parityEn, 1'b1);
        bus(1, csn_pkg::CTRL_OFS, 32'h3);
        repeat (3) @(posedge clk);
        chk(cardRstN, 1'b0);
        chk(cmdReady, 1'b0);
        waitFor(cmdReady, 4000);
        chk(coldReset, 1'b0);
        bus(0, csn_pkg::ATR_OFS, 0);
        chk(rd, 32'h0000_0037);
        bus(1, csn_pkg::CTRL_OFS, 32'h5);
        repeat (40) @(posedge clk);
        bus(0, csn_pkg::STATUS_OFS, 0);
        chk(rd[7:0], 8'h10);
        bus(1, csn_pkg::CTRL_OFS, 32'h9);
        repeat (3) @(posedge clk);
        chk(protoT1, 1'b1);
        chk(parityEn, 1'b0);
    endtask
    task automatic rejTest();
        bus(1, csn_pkg::CTRL_OFS, 32'h0);
        badAtr <= 1'b1;
        bus(1, csn_pkg::CTRL_OFS, 32'h1);
        errs = 0;
        for (int n = 0; n < 8000 && rejected !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (atrError === 1'b1) errs++;
        end
        chk(errs, 3);
        chk(rejected, 1'b1);
        repeat (2) @(posedge clk);
        chk(cardRstN, 1'b0);
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        negTest();
        stopTest();
        fallTest();
        rejTest();
        end_sim();
    end
    initial begin
        #1000000;
        failCount++;
        end_sim();
    end
endmodule
